// ---- common/accept_filter_pkg.sv ----
// package: register map, field layout and carrier types of the acceptance filter
package accept_filter_pkg;

  // register offsets (plain byte-wide register port)
  localparam logic [4:0] OFS_CODE_0  = 5'h00;  // accept code 0..7 at 0x00..0x07
  localparam logic [4:0] OFS_MASK_0  = 5'h08;  // accept mask 0..7 at 0x08..0x0f
  localparam logic [4:0] OFS_CTRL    = 5'h10;  // filter organization and hit index
  localparam logic [4:0] OFS_MODE    = 5'h11;  // init/sleep request and acknowledge
  localparam logic [4:0] OFS_TXERR   = 5'h12;  // transmit error counter
  localparam logic [4:0] OFS_RXSTAT  = 5'h13;  // foreground frame available flag
  localparam logic [4:0] OFS_FG_ID_0 = 5'h14;  // foreground identifier bytes 0..3

  localparam int ADDR_W = 5;
  localparam int DATA_W = 8;
  localparam int NUM_BYTES = 8;

  // control register fields
  localparam int CTRL_ORG_LSB = 4;  // filter organization at [5:4]
  localparam int CTRL_HIT_LSB = 0;  // filter hit index at [2:0]

  // mode register fields
  localparam int MODE_INIT_RQ = 0;
  localparam int MODE_SLEEP_RQ = 1;
  localparam int MODE_INIT_AK = 2;
  localparam int MODE_SLEEP_AK = 3;

  localparam int RXSTAT_FULL = 0;  // write 1 to release the foreground frame

  localparam logic [7:0] CODE_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [1:0] ORG_RST = 2'b00;
  localparam logic [7:0] INVALID_RD = 8'h00;  // returned for unmapped or locked reads

  typedef enum logic [1:0] {
    ORG_TWO_32  = 2'b00,
    ORG_FOUR_16 = 2'b01,
    ORG_EIGHT_8 = 2'b10,
    ORG_CLOSED  = 2'b11
  } filter_org_t;

  // register bus request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } reg_req_t;

  // frame identifier delivered by the receive engine
  typedef struct packed {
    logic       valid;     // one-cycle pulse at end of frame
    logic       extended;  // identifier is in extended format
    logic [31:0] id;       // identifier bytes 0..3, byte 0 in [31:24]
  } rx_frame_t;

endpackage : accept_filter_pkg

// ---- rtl/can_acceptance_filter.sv ----
// design: identifier acceptance filter with foreground buffer and error counter view
`timescale 1ns/100ps
`default_nettype none

module can_acceptance_filter
  import accept_filter_pkg::*;
(
  input  wire logic                          clk_i,          // module clock, 125 MHz
  input  wire logic                          nrst_i,         // async reset, active low
  input  wire accept_filter_pkg::reg_req_t   reg_req_i,      // register bus request
  output logic [accept_filter_pkg::DATA_W-1:0] reg_rdata_o,  // read data, cycle after read
  input  wire accept_filter_pkg::rx_frame_t  rx_frame_i,     // identifier from receive engine
  input  wire logic [7:0]                    tx_err_cnt_i,   // engine's transmit error counter
  input  wire logic                          init_ack_i,     // engine acknowledges init mode
  input  wire logic                          sleep_ack_i,    // engine acknowledges sleep mode
  output logic                               init_req_o,     // init request to engine
  output logic                               sleep_req_o,    // sleep request to engine
  output logic                               rx_avail_o,     // accepted frame in foreground
  output logic [2:0]                         hit_index_o,    // filter that took the frame
  output logic [31:0]                        fg_id_o         // foreground identifier bytes
);
  import accept_filter_pkg::*;

  logic [7:0]  code_q [NUM_BYTES];
  logic [7:0]  mask_q [NUM_BYTES];
  filter_org_t org_q;
  logic        init_rq_q;
  logic        sleep_rq_q;
  logic [1:0]  init_ak_sync_q;
  logic [1:0]  sleep_ak_sync_q;
  logic        bg_valid_q;
  logic        bg_ext_q;
  logic [31:0] bg_id_q;
  logic        fg_full_q;
  logic [31:0] fg_id_q;
  logic [2:0]  hit_q;
  logic [7:0]  rdata_q;
  logic        init_mode;
  logic        sleep_mode;
  logic        accept;
  logic [2:0]  hit_d;
  logic        wr_code;
  logic        wr_mask;
  logic        release_fg;

  // one byte compare: masked bits are don't-care, others must match
  function automatic logic byte_match(input logic [7:0] id, input logic [7:0] code,
                                      input logic [7:0] mask);
    byte_match = &((~(id ^ code)) | mask);
  endfunction : byte_match

  // acknowledges come from the engine's domain; synchronise before use
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      init_ak_sync_q  <= 2'b00;
      sleep_ak_sync_q <= 2'b00;
    end else begin
      init_ak_sync_q  <= {init_ak_sync_q[0], init_ack_i};
      sleep_ak_sync_q <= {sleep_ak_sync_q[0], sleep_ack_i};
    end
  end

  assign init_mode  = init_rq_q & init_ak_sync_q[1];
  assign sleep_mode = sleep_rq_q & sleep_ak_sync_q[1];
  assign wr_code = reg_req_i.wr && (reg_req_i.addr >= OFS_CODE_0)
                   && (reg_req_i.addr < OFS_MASK_0);
  assign wr_mask = reg_req_i.wr && (reg_req_i.addr >= OFS_MASK_0)
                   && (reg_req_i.addr < OFS_CTRL);
  assign release_fg = reg_req_i.wr && (reg_req_i.addr == OFS_RXSTAT)
                      && reg_req_i.wdata[RXSTAT_FULL];

  // code and mask bytes; writes outside init mode are dropped
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (int i = 0; i < NUM_BYTES; i++) begin
        code_q[i] <= CODE_RST;
        mask_q[i] <= MASK_RST;
      end
    end else if (init_mode) begin
      if (wr_code) begin
        code_q[reg_req_i.addr[2:0]] <= reg_req_i.wdata;
      end
      if (wr_mask) begin
        mask_q[reg_req_i.addr[2:0]] <= reg_req_i.wdata;
      end
    end
  end

  // organization is locked like the filter bytes
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      org_q <= filter_org_t'(ORG_RST);
    end else if (init_mode && reg_req_i.wr && reg_req_i.addr == OFS_CTRL) begin
      org_q <= filter_org_t'(reg_req_i.wdata[CTRL_ORG_LSB +: 2]);
    end
  end

  // mode requests, written any time
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      init_rq_q  <= 1'b0;
      sleep_rq_q <= 1'b0;
    end else if (reg_req_i.wr && reg_req_i.addr == OFS_MODE) begin
      init_rq_q  <= reg_req_i.wdata[MODE_INIT_RQ];
      sleep_rq_q <= reg_req_i.wdata[MODE_SLEEP_RQ];
    end
  end

  // background buffer: every frame lands here, last one overwrites
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bg_valid_q <= 1'b0;
      bg_ext_q   <= 1'b0;
      bg_id_q    <= 32'h0000_0000;
    end else begin
      bg_valid_q <= rx_frame_i.valid;
      if (rx_frame_i.valid) begin
        bg_ext_q <= rx_frame_i.extended;
        bg_id_q  <= rx_frame_i.id;
      end
    end
  end

  // filter evaluation on the background copy; lowest filter number wins
  always_comb begin
    logic [7:0] idb [4];
    logic       m;
    accept = 1'b0;
    hit_d  = 3'h0;
    m      = 1'b0;
    for (int b = 0; b < 4; b++) begin
      idb[b] = bg_id_q[31 - 8*b -: 8];
    end
    case (org_q)
      ORG_TWO_32: begin
        for (int f = 1; f >= 0; f--) begin // descending so filter 0 wins
          m = byte_match(idb[0], code_q[4*f], mask_q[4*f])
              & byte_match(idb[1], code_q[4*f+1], mask_q[4*f+1]);
          if (bg_ext_q) begin
            m = m & byte_match(idb[2], code_q[4*f+2], mask_q[4*f+2])
                  & byte_match(idb[3], code_q[4*f+3], mask_q[4*f+3]);
          end
          if (m) begin
            accept = 1'b1;
            hit_d  = 3'(f);
          end
        end
      end
      ORG_FOUR_16: begin
        for (int f = 3; f >= 0; f--) begin
          m = byte_match(idb[0], code_q[2*f], mask_q[2*f])
              & byte_match(idb[1], code_q[2*f+1], mask_q[2*f+1]);
          if (m) begin
            accept = 1'b1;
            hit_d  = 3'(f);
          end
        end
      end
      ORG_EIGHT_8: begin
        for (int f = 7; f >= 0; f--) begin
          m = byte_match(idb[0], code_q[f], mask_q[f]);
          if (m) begin
            accept = 1'b1;
            hit_d  = 3'(f);
          end
        end
      end
      ORG_CLOSED: begin
        accept = 1'b0;
      end
      default: begin
        accept = 1'b0;
      end
    endcase
  end

  // foreground buffer: loaded only by an accepted frame
  // limitation: a frame accepted while the foreground is full is lost
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      fg_full_q <= 1'b0;
      fg_id_q   <= 32'h0000_0000;
      hit_q     <= 3'h0;
    end else if (bg_valid_q && accept && !fg_full_q) begin
      fg_full_q <= 1'b1;
      fg_id_q   <= bg_id_q;
      hit_q     <= hit_d;
    end else if (release_fg) begin
      fg_full_q <= 1'b0;
    end
  end

  // read mux, data one cycle after the strobe
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_q <= 8'h00;
    end else if (reg_req_i.rd) begin
      if (reg_req_i.addr < OFS_MASK_0) begin
        rdata_q <= code_q[reg_req_i.addr[2:0]];
      end else if (reg_req_i.addr < OFS_CTRL) begin
        rdata_q <= mask_q[reg_req_i.addr[2:0]];
      end else if (reg_req_i.addr == OFS_CTRL) begin
        rdata_q <= {2'b00, org_q, 1'b0, hit_q};
      end else if (reg_req_i.addr == OFS_MODE) begin
        rdata_q <= {4'h0, sleep_ak_sync_q[1], init_ak_sync_q[1], sleep_rq_q, init_rq_q};
      end else if (reg_req_i.addr == OFS_TXERR) begin
        // counter is unstable outside quiet modes, so it reads zero there
        rdata_q <= (init_mode || sleep_mode) ? tx_err_cnt_i : INVALID_RD;
      end else if (reg_req_i.addr == OFS_RXSTAT) begin
        rdata_q <= {7'h00, fg_full_q};
      end else if (reg_req_i.addr >= OFS_FG_ID_0 && reg_req_i.addr < 5'h18) begin
        rdata_q <= fg_id_q[31 - 8*reg_req_i.addr[1:0] -: 8];
      end else begin
        rdata_q <= INVALID_RD;
      end
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign reg_rdata_o = rdata_q;
  assign init_req_o  = init_rq_q;
  assign sleep_req_o = sleep_rq_q;
  assign rx_avail_o  = fg_full_q;
  assign hit_index_o = hit_q;
  assign fg_id_o     = fg_id_q;

endmodule : can_acceptance_filter

`default_nettype wire

// ---- sim/can_acceptance_filter_assertions.sv ----
// checker: port-level properties of the acceptance filter
`timescale 1ns/100ps
`default_nettype none
module can_acceptance_filter_assertions
  import accept_filter_pkg::*;
(
  input wire logic                        clk_i,        // clock
  input wire logic                        nrst_i,       // reset, low
  input wire accept_filter_pkg::reg_req_t  reg_req_i,    // bus request
  input wire logic [7:0]                  reg_rdata_o,  // read data
  input wire accept_filter_pkg::rx_frame_t rx_frame_i,   // frame in
  input wire logic                        init_req_o,   // init request
  input wire logic                        sleep_req_o,  // sleep request
  input wire logic                        rx_avail_o,   // frame held
  input wire logic [2:0]                  hit_index_o,  // hit filter
  input wire logic [31:0]                 fg_id_o       // held id
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  // release strobe: clears the frame a cycle later; a load in the same cycle is blocked while the frame is held
  wire rel = reg_req_i.wr && reg_req_i.addr == OFS_RXSTAT && reg_req_i.wdata[0];
  a_rdata_idle: assert property (!$past(reg_req_i.rd) |-> reg_rdata_o == 8'h00)
    else $error("read data not zero");
  a_unmapped_zero: assert property (reg_req_i.rd && reg_req_i.addr > 5'h17
    |=> reg_rdata_o == 8'h00) else $error("unmapped read not zero");
  a_txerr_locked: assert property (reg_req_i.rd && reg_req_i.addr == OFS_TXERR
    && !init_req_o && !sleep_req_o |=> reg_rdata_o == 8'h00) else $error("txerr leaked");
  a_avail_cause: assert property ($rose(rx_avail_o) |-> $past(rx_frame_i.valid, 2))
    else $error("avail without frame");
  a_load_id: assert property ($rose(rx_avail_o) |-> fg_id_o == $past(rx_frame_i.id, 2))
    else $error("wrong id loaded");
  a_avail_clear: assert property ($fell(rx_avail_o) |-> $past(rel))
    else $error("avail dropped alone");
  a_fg_hold: assert property (rx_avail_o && $past(rx_avail_o) && !$past(rel)
    && !$past(rel, 2) |-> $stable(fg_id_o) && $stable(hit_index_o)) else $error("held frame moved");
  a_init_cause: assert property ($rose(init_req_o) |-> $past(reg_req_i.wr
    && reg_req_i.addr == OFS_MODE && reg_req_i.wdata[MODE_INIT_RQ])) else $error("init req alone");
endmodule : can_acceptance_filter_assertions
bind can_acceptance_filter can_acceptance_filter_assertions chk (.*);
`default_nettype wire

// ---- sim/rx_engine_model.sv ----
// model: receive engine giving identifiers and mode acknowledges
`timescale 1ns/100ps
`default_nettype none
module rx_engine_model
  import accept_filter_pkg::*;
(
  input  wire logic                  clk_i,        // clock
  input  wire logic                  init_req_i,   // init request
  input  wire logic                  sleep_req_i,  // sleep request
  input  wire logic [2:0]            dly_i,        // ack delay
  output logic                       init_ack_o,   // init ack
  output logic                       sleep_ack_o,  // sleep ack
  output accept_filter_pkg::rx_frame_t frame_o,    // frame out
  output logic [7:0]                 tx_err_o      // error count
);
  logic [2:0] wait_q;
  initial {init_ack_o, sleep_ack_o, frame_o, tx_err_o, wait_q} = '0;
  // acks follow requests dly_i + 1 cycles later, prompt or slow
  always @(posedge clk_i) begin
    if ({sleep_req_i, init_req_i} == {sleep_ack_o, init_ack_o}) wait_q <= 3'h0;
    else if (wait_q >= dly_i) {sleep_ack_o, init_ack_o} <= {sleep_req_i, init_req_i};
    else wait_q <= wait_q + 3'h1;
  end
  // idle lines carry the inverse so a stale id never looks fresh
  task send(input logic ext, input logic [31:0] id);
    @(posedge clk_i);
    frame_o <= '{1'b1, ext, id};
    @(posedge clk_i);
    frame_o <= '{1'b0, ~ext, ~id};
    tx_err_o <= tx_err_o + 8'h03;
  endtask : send
endmodule : rx_engine_model
`default_nettype wire

// ---- sim/can_acceptance_filter_tb.sv ----
// testbench: register access, mode handshake, filtering of random frames
`timescale 1ns/100ps
`default_nettype none
module can_acceptance_filter_tb;
  import accept_filter_pkg::*;
  logic        clk_i, nrst_i, iack, sack, ireq, sreq, avail, rd1;
  reg_req_t    req;
  rx_frame_t   frame;
  logic [7:0]  rdata, txe, code [8], mask [8], expq [$];
  logic [2:0]  hit, dly;
  logic [1:0]  org;
  logic [31:0] fgid;
  string       nameq [$];
  int          n_mismatch, checked;
  can_acceptance_filter uut (.clk_i(clk_i), .nrst_i(nrst_i), .reg_req_i(req),
    .reg_rdata_o(rdata), .rx_frame_i(frame), .tx_err_cnt_i(txe), .init_ack_i(iack),
    .sleep_ack_i(sack), .init_req_o(ireq), .sleep_req_o(sreq), .rx_avail_o(avail),
    .hit_index_o(hit), .fg_id_o(fgid));
  rx_engine_model pe (.clk_i(clk_i), .init_req_i(ireq), .sleep_req_i(sreq), .dly_i(dly),
    .init_ack_o(iack), .sleep_ack_o(sack), .frame_o(frame), .tx_err_o(txe));
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // read data stands one cycle only, so compare against the oldest note then
  always @(posedge clk_i) begin
    if (rd1) chk(nameq.pop_front(), expq.pop_front(), rdata);
    rd1 <= req.rd;
  end
  task automatic bus(input logic [4:0] a, input logic [7:0] d, input logic w);
    @(posedge clk_i);
    req <= '{a, d, w, ~w};
    @(posedge clk_i);
    req <= '0;
  endtask : bus
  task automatic rd(input logic [4:0] a, input logic [7:0] e, input string nm);
    expq.push_back(e);
    nameq.push_back(nm);
    bus(a, 8'h00, 1'b0);
  endtask : rd
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : report_and_stop
  task automatic mode(input logic [1:0] m);
    int n;
    dly <= 3'($urandom);
    bus(OFS_MODE, {6'h0, m}, 1'b1);
    for (n = 0; n < 40 && {sack, iack} !== m; n++) @(posedge clk_i);
    if (n == 40) begin
      n_mismatch++;
      report_and_stop();
    end
    repeat (3) @(posedge clk_i);
    chk("req pins", {6'h0, m}, {6'h0, sreq, ireq});
    rd(OFS_MODE, {4'h0, m, m}, "mode");
  endtask : mode
  // lowest numbered matching filter, -1 when none
  function automatic int ref_hit(input logic ext, input logic [31:0] id);
    int w, n;
    if (org == 2'b11) return -1;
    w = 4 >> org;
    n = (w == 4 && !ext) ? 2 : w;
    for (int f = 0; f < 8 / w; f++) begin
      int ok;
      ok = 1;
      for (int k = 0; k < n; k++)
        if (((id[31-8*k -: 8] ^ code[f*w+k]) & ~mask[f*w+k]) != 8'h00) ok = 0;
      if (ok) return f;
    end
    return -1;
  endfunction : ref_hit
  // id built to match a random filter, masked bits left random
  function automatic logic [31:0] near();
    logic [31:0] id;
    int w, f;
    id = $urandom;
    w = org == 2'b11 ? 4 : 4 >> org;
    f = $urandom % (8 / w);
    for (int k = 0; k < w; k++)
      id[31-8*k -: 8] = code[f*w+k] ^ (id[31-8*k -: 8] & mask[f*w+k]);
    return id;
  endfunction : near
  task automatic frm(input logic ext, input logic [31:0] id);
    int h;
    h = ref_hit(ext, id);
    pe.send(ext, id);
    repeat (3) @(posedge clk_i);
    chk("avail pin", {7'h0, h >= 0}, {7'h0, avail});
    rd(OFS_RXSTAT, {7'h0, h >= 0}, "avail");
    if (h >= 0) begin
      chk("hit pin", {5'h0, 3'(h)}, {5'h0, hit});
      for (int k = 0; k < 4; k++) chk("fg pin", id[31-8*k -: 8], fgid[31-8*k -: 8]);
      rd(OFS_CTRL, {2'h0, org, 1'b0, 3'(h)}, "hit");
      for (int k = 0; k < 4; k++) rd(OFS_FG_ID_0 + 5'(k), id[31-8*k -: 8], "fg id");
      bus(OFS_RXSTAT, 8'h01, 1'b1);
    end
  endtask : frm
  initial begin
    {nrst_i, req, rd1, org, n_mismatch, checked} = '0;
    dly = 3'h2;
    void'($urandom(76876));
    repeat (3) @(posedge clk_i);
    nrst_i <= 1'b1;
    for (int i = 0; i < 16; i++) rd(5'(i), 8'h00, "reset");
    rd(5'h1f, 8'h00, "unmapped");
    bus(OFS_CODE_0, 8'ha5, 1'b1);
    rd(OFS_CODE_0, 8'h00, "locked");
    // rejected frame bumps the counter so the locked read has something to hide
    pe.send(1'b1, 32'hffff_ffff);
    rd(OFS_TXERR, 8'h00, "txerr run");
    mode(2'b10);
    rd(OFS_TXERR, txe, "txerr sleep");
    mode(2'b01);
    bus(OFS_TXERR, 8'h5a, 1'b1);
    rd(OFS_TXERR, txe, "txerr init");
    $display("test reset and modes done");
    for (int o = 0; o < 4; o++) begin
      org = 2'(o);
      mode(2'b01);
      for (int i = 0; i < 8; i++) begin
        code[i] = 8'($urandom);
        mask[i] = (8'($urandom) & 8'h5b) | (i % 4 == 1 ? 8'h07 : 8'h00);
        bus(OFS_CODE_0 + 5'(i), code[i], 1'b1);
        bus(OFS_MASK_0 + 5'(i), mask[i], 1'b1);
        rd(OFS_CODE_0 + 5'(i), code[i], "code");
        rd(OFS_MASK_0 + 5'(i), mask[i], "mask");
      end
      bus(OFS_CTRL, {2'h0, org, 4'h0}, 1'b1);
      mode(2'b00);
      for (int j = 0; j < 16; j++) frm(j[1], j[0] ? 32'($urandom) : near());
      $display("test organization %0d done", o);
    end
    repeat (4) @(posedge clk_i);
    report_and_stop();
  end
  // hang guard
  initial begin
    repeat (60000) @(posedge clk_i);
    n_mismatch++;
    report_and_stop();
  end
endmodule : can_acceptance_filter_tb
`default_nettype wire
